/* hw/sram_array_controller.sv */
`timescale 1ns/100ps
module sram_array_controller
    import sram_ctrl_pkg::*;
(
    input  wire logic                               clk,
    input  wire logic                               sys_rst,
    input  wire logic                               hsel,
    input  wire logic [31:0]                        haddr,
    input  wire logic [1:0]                         htrans,
    input  wire logic                               hwrite,
    input  wire logic [2:0]                         hsize,
    input  wire logic [63:0]                        hwdata,
    input  wire logic                               hready,
    output logic                                    hreadyout,
    output logic                                    hresp,
    output logic      [63:0]                        hrdata,
    output sram_ctrl_pkg::array_req_t               array_req,
    input  wire sram_ctrl_pkg::code_word_t [1:0]    array_rdata,
    input  wire sram_ctrl_pkg::ecc_cfg_t            ecc_cfg,
    output sram_ctrl_pkg::ecc_evt_t                 ecc_evt,
    output logic                                    fault_dbl
);

    typedef enum logic [2:0] {
        S_IDLE, S_RD_ISSUE, S_RD_DATA, S_WR, S_RMW_WR, S_ERR
    } state_t;

    state_t             state;
    state_t             next_state;
    logic [31:0]        dp_addr;
    logic [2:0]         dp_size;
    logic               hi_pend;
    logic [ROW_W-1:0]   hi_row;
    code_word_t         hi_word;
    ecc_evt_t           next_evt;

    logic               accept;
    logic               lane;
    logic               dword;
    logic               sub;
    logic               go;
    logic               rd_bad;
    logic               rmw_bad;
    logic               el;
    logic [LANES-1:0]   used;
    logic [LANES-1:0]   sg;
    logic [LANES-1:0]   db;
    logic [3:0]         bm;
    logic               chk_state;
    code_word_t [1:0]   cw;
    logic [31:0]        corr [LANES];
    logic [31:0]        wr_data [LANES];
    logic [CHK_W-1:0]   enc_chk [LANES];
    logic [31:0]        dec_data [LANES];
    logic [CHK_W-1:0]   dec_syn [LANES];
    logic [LANES-1:0]   dec_sgl;
    logic [LANES-1:0]   dec_dbl;

    // only non-sequential and sequential transfers are taken
    assign accept = hsel && htrans[1] && hready;
    // row from address, lane from word bit
    assign lane   = dp_addr[LANE_BIT];
    assign dword  = (dp_size == SIZE_DWORD);
    assign sub    = (dp_size < SIZE_WORD);
    assign bm     = byte_mask(dp_size, dp_addr[1:0]);
    assign used   = lane_mask(dword, lane);

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [31:0] waddr;
        assign waddr = {dp_addr[31:3], 1'(l), 2'h0};
        // decode with the word's full bus address
        sram_ecc_codec u_dec (
            .data_in    (array_rdata[l].data),
            .addr_in    (waddr),
            .chk_in     (array_rdata[l].chk),
            .chk_out    (),
            .data_out   (dec_data[l]),
            .syndrome   (dec_syn[l]),
            .single_err (dec_sgl[l]),
            .double_err (dec_dbl[l])
        );
        // encode each written word with its address
        sram_ecc_codec u_enc (
            .data_in    (wr_data[l]),
            .addr_in    (waddr),
            .chk_in     (7'h00),
            .chk_out    (enc_chk[l]),
            .data_out   (),
            .syndrome   (),
            .single_err (),
            .double_err ()
        );
        assign corr[l] = ecc_cfg.check_en ? dec_data[l] : array_rdata[l].data;
        // merge new bytes into the corrected old word
        assign wr_data[l] = (state == S_RMW_WR)
            ? ((hwdata[32*l +: 32] & {{8{bm[3]}}, {8{bm[2]}},
                                      {8{bm[1]}}, {8{bm[0]}}})
               | (corr[l] & ~{{8{bm[3]}}, {8{bm[2]}},
                              {8{bm[1]}}, {8{bm[0]}}}))
            : hwdata[32*l +: 32];
        // deliberate fault insertion on the stored word
        assign cw[l].data = wr_data[l]
            ^ (ecc_cfg.inject_en ? ecc_cfg.inj_data : 32'h0000_0000);
        assign cw[l].chk  = enc_chk[l]
            ^ (ecc_cfg.inject_en ? ecc_cfg.inj_chk : 7'h00);
        assign hrdata[32*l +: 32] = corr[l];
    end

    assign chk_state = (state == S_RD_DATA) || (state == S_RMW_WR);
    assign sg = dec_sgl & used & {LANES{ecc_cfg.check_en && chk_state}};
    assign db = dec_dbl & used & {LANES{ecc_cfg.check_en && chk_state}};
    assign el = !(sg[0] || db[0]);
    assign rd_bad  = (state == S_RD_DATA) && (|db);
    assign rmw_bad = (state == S_RMW_WR) && (|db);

    // Array port: pending high word always wins, so it never starves
    always_comb begin
        array_req       = '0;
        array_req.row   = dp_addr[ROW_MSB:ROW_LSB];
        array_req.wdata = cw;
        go              = 1'b0;
        if (hi_pend) begin
            // second word write of a 64-bit store
            array_req.en       = 1'b1;
            array_req.we       = 2'h2;
            array_req.row      = hi_row;
            array_req.wdata[1] = hi_word;
        end else begin
            unique case (state)
                S_RD_ISSUE: begin
                    array_req.en = 1'b1;
                    go           = 1'b1;
                end
                S_WR: begin
                    array_req.en = 1'b1;
                    array_req.we = sub ? 2'h0 : lane_mask(1'b0, lane);
                    go           = 1'b1;
                end
                S_RMW_WR: begin
                    array_req.en = !rmw_bad;
                    array_req.we = rmw_bad ? 2'h0 : lane_mask(1'b0, lane);
                    go           = 1'b1;
                end
                S_IDLE, S_RD_DATA, S_ERR: begin
                    // early read only when no array wait is needed
                    if (accept && !hwrite && !ARRAY_WS) begin
                        array_req.en  = 1'b1;
                        array_req.row = haddr[ROW_MSB:ROW_LSB];
                    end
                end
            endcase
        end
    end

    // ready and error answer of each data phase
    always_comb begin
        hreadyout = 1'b1;
        hresp     = 1'b0;
        unique case (state)
            S_IDLE:     hreadyout = 1'b1;
            S_RD_ISSUE: hreadyout = 1'b0;
            S_RD_DATA: begin
                hreadyout = !rd_bad;
                hresp     = rd_bad;
            end
            // word and double-word writes finish with no wait unless a pending high-word write holds the port
            S_WR:       hreadyout = go && !sub;
            S_RMW_WR: begin
                hreadyout = go && !rmw_bad;
                hresp     = rmw_bad;
            end
            S_ERR:      hresp = 1'b1;
        endcase
    end

    always_comb begin
        next_state = state;
        unique case (state)
            S_RD_ISSUE: if (go) next_state = S_RD_DATA;
            S_RD_DATA:  if (rd_bad) next_state = S_ERR;
            // sub-word write reads the old word first
            S_WR:       if (go && sub) next_state = S_RMW_WR;
            S_RMW_WR:   if (rmw_bad) next_state = S_ERR;
            S_IDLE, S_ERR: next_state = state;
        endcase
        if (hreadyout) begin
            if (!accept) begin
                next_state = S_IDLE;
            end else if (hwrite) begin
                next_state = S_WR;
            end else if (array_req.en && !hi_pend && (state == S_IDLE
                     || state == S_RD_DATA || state == S_ERR)) begin
                next_state = S_RD_DATA;
            end else begin
                next_state = S_RD_ISSUE;
            end
        end
    end

    always_comb begin
        next_evt          = '0;
        // event report toward the status module
        next_evt.single   = |sg;
        next_evt.dbl      = |db;
        next_evt.write    = (state == S_RMW_WR);
        next_evt.addr     = {dp_addr[31:3], el, 2'h0};
        next_evt.syndrome = dec_syn[el];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state   <= S_IDLE;
            dp_addr <= 32'h0000_0000;
            dp_size <= SIZE_BYTE;
        end else begin
            state <= next_state;
            if (accept) begin
                dp_addr <= haddr;
                dp_size <= hsize;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hi_pend <= 1'b0;
            hi_row  <= '0;
            hi_word <= '0;
        end else begin
            // hold the high word for the following cycle
            hi_pend <= (state == S_WR) && go && dword;
            hi_row  <= dp_addr[ROW_MSB:ROW_LSB];
            hi_word <= cw[1];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ecc_evt   <= '0;
            fault_dbl <= 1'b0;
        end else begin
            ecc_evt   <= next_evt;
            // double error also flagged to the fault unit
            fault_dbl <= next_evt.dbl;
        end
    end

endmodule : sram_array_controller

/* hw/sram_ctrl_pkg.sv */
package sram_ctrl_pkg;

    localparam int DATA_W     = 32;
    localparam int CHK_W      = 7;
    localparam int ADDR_W     = 32;
    localparam int ROW_W      = 14;
    localparam int ROW_LSB    = 3;
    localparam int ROW_MSB    = ROW_LSB + ROW_W - 1;
    localparam int LANE_BIT   = 2;
    localparam int LANES      = 2;
    localparam int DATA_COL_W = 3;
    localparam int ADDR_COL_W = 5;
    localparam int ADDR_COL_N = 21;

    localparam logic [2:0] SIZE_BYTE  = 3'h0;
    localparam logic [2:0] SIZE_HALF  = 3'h1;
    localparam logic [2:0] SIZE_WORD  = 3'h2;
    localparam logic [2:0] SIZE_DWORD = 3'h3;

    // 20 MHz system clock; the array needs a wait state above 80 MHz
    localparam logic [31:0] SYS_CLK_HZ    = 32'h0131_2D00;
    localparam logic [31:0] NO_WS_MAX_HZ  = 32'h04C4_B400;
    localparam logic        ARRAY_WS      = (SYS_CLK_HZ > NO_WS_MAX_HZ);

    typedef struct packed {
        logic [CHK_W-1:0]  chk;
        logic [DATA_W-1:0] data;
    } code_word_t;

    typedef struct packed {
        logic                   en;
        logic [LANES-1:0]       we;
        logic [ROW_W-1:0]       row;
        code_word_t [LANES-1:0] wdata;
    } array_req_t;

    typedef struct packed {
        logic              check_en;
        logic              inject_en;
        logic [DATA_W-1:0] inj_data;
        logic [CHK_W-1:0]  inj_chk;
    } ecc_cfg_t;

    typedef struct packed {
        logic              single;
        logic              dbl;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [CHK_W-1:0]  syndrome;
    } ecc_evt_t;

    function automatic logic [LANES-1:0] lane_mask(input logic dword,
                                                   input logic lane);
        return dword ? 2'h3 : (lane ? 2'h2 : 2'h1);
    endfunction : lane_mask

    function automatic logic [3:0] byte_mask(input logic [2:0] size,
                                             input logic [1:0] lsb);
        logic [3:0] m;
        m = 4'h0;
        if (size == SIZE_BYTE) begin
            m = 4'(4'h1 << lsb);
        end else if (size == SIZE_HALF) begin
            m = lsb[1] ? 4'hC : 4'h3;
        end else begin
            m = 4'hF;
        end
        return m;
    endfunction : byte_mask

endpackage : sram_ctrl_pkg

/* hw/sram_ecc_codec.sv */
`timescale 1ns/100ps
module sram_ecc_codec
    import sram_ctrl_pkg::*;
(
    input  wire logic [sram_ctrl_pkg::DATA_W-1:0] data_in,
    input  wire logic [sram_ctrl_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [sram_ctrl_pkg::CHK_W-1:0]  chk_in,
    output logic      [sram_ctrl_pkg::CHK_W-1:0]  chk_out,
    output logic      [sram_ctrl_pkg::DATA_W-1:0] data_out,
    output logic      [sram_ctrl_pkg::CHK_W-1:0]  syndrome,
    output logic                                  single_err,
    output logic                                  double_err
);

    // Odd-weight columns: weight 3 for data, weight 5 for address bits
    function automatic logic [CHK_W-1:0] ecc_col(input int idx,
                                                 input int weight);
        int               n;
        logic [CHK_W-1:0] col;
        n   = 0;
        col = '0;
        for (int v = 1; v < 128; v++) begin
            if ($countones(7'(v)) == weight) begin
                if (n == idx) begin
                    col = 7'(v);
                end
                n++;
            end
        end
        return col;
    endfunction : ecc_col

    logic [CHK_W-1:0]  dcol [DATA_W];
    logic [CHK_W-1:0]  acol [ADDR_W];
    logic [DATA_W-1:0] flip;

    for (genvar g = 0; g < DATA_W; g++) begin : g_col
        assign dcol[g] = ecc_col(g, DATA_COL_W);
        assign acol[g] = ecc_col(g % ADDR_COL_N, ADDR_COL_W);
    end

    always_comb begin
        chk_out = '0;
        flip    = '0;
        // seven check bits over data and address
        for (int i = 0; i < DATA_W; i++) begin
            if (data_in[i]) chk_out = chk_out ^ dcol[i];
        end
        for (int j = 0; j < ADDR_W; j++) begin
            if (addr_in[j]) chk_out = chk_out ^ acol[j];
        end
        syndrome = chk_out ^ chk_in;
        for (int i = 0; i < DATA_W; i++) begin
            flip[i] = (syndrome == dcol[i]);
        end
    end

    // correct single, flag double errors
    // An address-column syndrome never matches data, so it counts as double
    assign single_err = (^syndrome)
        && ((|flip) || ($countones(syndrome) == 1));
    assign double_err = (|syndrome) && !single_err;
    assign data_out   = data_in ^ flip;

endmodule : sram_ecc_codec

/* verif/sram_ctrl_props.sv */
`timescale 1ns/100ps
module sram_ctrl_props
    import sram_ctrl_pkg::*;
(
    input wire logic                            clk,
    input wire logic                            sys_rst,
    input wire logic                            hsel,
    input wire logic [31:0]                     haddr,
    input wire logic [1:0]                      htrans,
    input wire logic                            hwrite,
    input wire logic [2:0]                      hsize,
    input wire logic [63:0]                     hwdata,
    input wire logic                            hready,
    input wire logic                            hreadyout,
    input wire logic                            hresp,
    input wire logic [63:0]                     hrdata,
    input wire sram_ctrl_pkg::array_req_t       array_req,
    input wire sram_ctrl_pkg::code_word_t [1:0] array_rdata,
    input wire sram_ctrl_pkg::ecc_cfg_t         ecc_cfg,
    input wire sram_ctrl_pkg::ecc_evt_t         ecc_evt,
    input wire logic                            fault_dbl
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire taken  = hsel && htrans[1] && hready;
    wire dw_wr  = taken && hwrite && (hsize == SIZE_DWORD);
    wire sub_wr = taken && hwrite && (hsize < SIZE_WORD);
    logic dw_dp;
    logic wr_dp;

    // Kind of transfer now in its data phase, for port collisions
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dw_dp <= 1'b0;
            wr_dp <= 1'b0;
        end else if (hready) begin
            dw_dp <= dw_wr;
            wr_dp <= taken && hwrite;
        end
    end

    fault_mirror_a: assert property (fault_dbl == ecc_evt.dbl)
        else $error("fault_dbl differs from ecc_evt.dbl");
    err_second_a: assert property ((hresp && !hreadyout) |=>
        (hresp && hreadyout)) else $error("error response cut short");
    err_first_a: assert property ((hresp && hreadyout) |->
        $past(hresp && !hreadyout)) else $error("error response one cycle");
    read_row_a: assert property ((taken && !hwrite && array_req.en
        && array_req.we == 2'h0) |-> array_req.row == haddr[ROW_MSB:ROW_LSB])
        else $error("array row does not match address");
    dword_split_a: assert property (dw_wr ##1 hreadyout |->
        (array_req.en && array_req.we == 2'h1) ##1
        (array_req.en && array_req.we == 2'h2))
        else $error("dword write not split into two lanes");
    word_nowait_a: assert property ((taken && hwrite
        && hsize >= SIZE_WORD && !dw_dp) |=> hreadyout)
        else $error("word write inserted a wait");
    sub_rmw_a: assert property (sub_wr |=>
        !hreadyout ##[1:2] hreadyout)
        else $error("sub-word write wait count wrong");
    read_nowait_a: assert property ((taken && !hwrite && !wr_dp
        && !$past(wr_dp && hready)
        && !$past(taken) && !$past(taken, 2)) |=> (hreadyout || hresp))
        else $error("read on a free port waited");
    evt_gate_a: assert property ((ecc_evt.single || ecc_evt.dbl)
        |-> $past(ecc_cfg.check_en)) else $error("event while checks off");
endmodule : sram_ctrl_props

bind sram_array_controller sram_ctrl_props i_sram_ctrl_props (
    .clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .array_req, .array_rdata,
    .ecc_cfg, .ecc_evt, .fault_dbl);

/* verif/sram_array_model.sv */
`timescale 1ns/100ps
module sram_array_model
    import sram_ctrl_pkg::*;
(
    input  wire logic                            clk,
    input  wire sram_ctrl_pkg::array_req_t       array_req,
    input  wire logic                            row_flip,
    output sram_ctrl_pkg::code_word_t [1:0]      array_rdata
);
    code_word_t [1:0] mem [2**ROW_W];
    // Row flip mimics a broken address decoder inside the array
    wire [ROW_W-1:0] rd_row = array_req.row ^ ROW_W'(row_flip);
    wire             rd     = array_req.en && (array_req.we == 2'h0);
    initial array_rdata = '0;
    always @(posedge clk) begin
        // Data is valid one cycle only, so stale reuse shows up
        if (rd) begin
            array_rdata <= mem[rd_row];
        end else begin
            array_rdata <= ~array_rdata;
        end
        for (int i = 0; i < LANES; i++) begin
            if (array_req.en && array_req.we[i]) begin
                mem[array_req.row][i] <= array_req.wdata[i];
            end
        end
    end
endmodule : sram_array_model

/* verif/ecc_sram_array_controller_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) compare(nm, 64'(e), 64'(g));
module ecc_sram_array_controller_tb;
    import sram_ctrl_pkg::*;
    logic             clk = 0;
    logic             sys_rst, hsel, hwrite, hreadyout, hresp, fault_dbl;
    logic             row_flip, resp, ev_single, ev_dbl, ev_write;
    logic [31:0]      haddr, ev_addr;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [63:0]      hwdata, hrdata, rdat;
    wire              hready;
    array_req_t       array_req;
    code_word_t [1:0] array_rdata;
    ecc_cfg_t         ecc_cfg;
    ecc_evt_t         ecc_evt;
    int               miscompares = 0, n_compared = 0, cycles = 0, waits;

    always #25 clk = ~clk;
    assign hready = hreadyout;
    sram_array_controller i_sram_array_controller (.clk, .sys_rst, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
        .hresp, .hrdata, .array_req, .array_rdata, .ecc_cfg, .ecc_evt,
        .fault_dbl);
    sram_array_model i_sram_array_model (.clk, .array_req, .row_flip,
        .array_rdata);

    task automatic compare(input string nm, input logic [63:0] e, g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : compare

    task automatic sample();
        ev_single = ev_single | (ecc_evt.single === 1'b1);
        ev_dbl = ev_dbl | (fault_dbl === 1'b1);
        if (ecc_evt.single === 1'b1) begin
            ev_addr = ecc_evt.addr;
        end
        if (fault_dbl === 1'b1) begin
            ev_write = ecc_evt.write;
        end
    endtask : sample

    task automatic ahb(input logic wr, input logic [2:0] sz,
                       input logic [31:0] a, input logic [63:0] wd);
        waits = 0;
        resp = 0;
        ev_single = 0;
        ev_dbl = 0;
        ev_write = 0;
        hsel = 1;
        htrans = 2'h2;
        hwrite = wr;
        hsize = sz;
        haddr = a;
        @(posedge clk);
        #1;
        hsel = 0;
        htrans = 2'h0;
        hwdata = wd;
        @(negedge clk);
        while (hreadyout !== 1'b1 && waits < 8) begin
            sample();
            resp = resp | (hresp === 1'b1);
            waits++;
            @(negedge clk);
        end
        sample();
        resp = resp | (hresp === 1'b1);
        rdat = hrdata;
        @(posedge clk);
        #1;
        hwdata = ~wd;
        @(negedge clk);
        sample();
        @(posedge clk);
        #1;
    endtask : ahb

    task automatic t_word();
        ahb(1, SIZE_WORD, 32'h0000_0100, 64'h0000_0000_1122_3344);
        `CHK("word write waits", 0, waits)
        ahb(1, SIZE_WORD, 32'h0000_0104, 64'h5566_7788_0000_0000);
        ahb(0, SIZE_WORD, 32'h0000_0104, 64'h0);
        `CHK("word read waits", 0, waits)
        `CHK("word read data", 32'h5566_7788, rdat[63:32])
        `CHK("word read resp", 0, resp)
    endtask : t_word

    task automatic t_sub();
        ahb(1, SIZE_BYTE, 32'h0000_0101, 64'h0000_0000_0000_AA00);
        `CHK("byte write waits", 1, waits)
        ahb(1, SIZE_HALF, 32'h0000_0106, 64'hBEEF_0000_0000_0000);
        `CHK("half write waits", 1, waits)
        ahb(0, SIZE_DWORD, 32'h0000_0100, 64'h0);
        `CHK("merged dword", 64'hBEEF_7788_1122_AA44, rdat)
    endtask : t_sub

    task automatic t_dword();
        ahb(1, SIZE_DWORD, 32'h0000_0300, 64'hA5A5_0F0F_1234_5678);
        `CHK("dword write waits", 0, waits)
        ahb(0, SIZE_DWORD, 32'h0000_0300, 64'h0);
        `CHK("dword read", 64'hA5A5_0F0F_1234_5678, rdat)
        `CHK("dword resp", 0, resp)
    endtask : t_dword

    task automatic t_single();
        ecc_cfg.inject_en = 1;
        ecc_cfg.inj_data = 32'h0000_0010;
        ahb(1, SIZE_WORD, 32'h0000_0110, 64'h0000_0000_CAFE_0001);
        ecc_cfg.inject_en = 0;
        ahb(0, SIZE_WORD, 32'h0000_0110, 64'h0);
        `CHK("corrected word", 32'hCAFE_0001, rdat[31:0])
        `CHK("single event", 1, ev_single)
        `CHK("single addr", 32'h0000_0110, ev_addr)
        ecc_cfg.check_en = 0;
        ahb(0, SIZE_WORD, 32'h0000_0110, 64'h0);
        `CHK("raw word", 32'hCAFE_0011, rdat[31:0])
        `CHK("silent event", 0, ev_single)
        ecc_cfg = '{1'b1, 1'b1, 32'h0000_0000, 7'h01};
        ahb(1, SIZE_WORD, 32'h0000_0110, 64'h0000_0000_CAFE_0001);
        ecc_cfg.inject_en = 0;
        ahb(0, SIZE_WORD, 32'h0000_0110, 64'h0);
        ecc_cfg.inj_chk = 7'h00;
        `CHK("check bit word", 32'hCAFE_0001, rdat[31:0])
        `CHK("check bit event", 1, ev_single)
    endtask : t_single

    task automatic t_double();
        ecc_cfg.inject_en = 1;
        ecc_cfg.inj_data = 32'h0000_0003;
        ahb(1, SIZE_WORD, 32'h0000_0118, 64'h0000_0000_0BAD_F00D);
        ecc_cfg.inject_en = 0;
        ahb(0, SIZE_WORD, 32'h0000_0118, 64'h0);
        `CHK("double resp", 1, resp)
        `CHK("double fault", 1, ev_dbl)
        `CHK("read event kind", 0, ev_write)
        ahb(1, SIZE_BYTE, 32'h0000_0118, 64'h0000_0000_0000_0077);
        `CHK("rmw double resp", 1, resp)
        `CHK("rmw double fault", 1, ev_dbl)
        `CHK("rmw event kind", 1, ev_write)
    endtask : t_double

    task automatic t_addr();
        ahb(1, SIZE_WORD, 32'h0000_0200, 64'h0000_0000_1111_2222);
        ahb(1, SIZE_WORD, 32'h0000_0208, 64'h0000_0000_3333_4444);
        row_flip = 1;
        ahb(0, SIZE_WORD, 32'h0000_0200, 64'h0);
        row_flip = 0;
        `CHK("decoder fault resp", 1, resp)
        `CHK("decoder fault event", 1, ev_dbl)
        ahb(0, SIZE_WORD, 32'h0000_0200, 64'h0);
        `CHK("healthy read", 32'h1111_2222, rdat[31:0])
    endtask : t_addr

    task automatic t_reset();
        sys_rst = 1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("reset ready", 1, hreadyout)
        `CHK("reset resp", 0, hresp)
        `CHK("reset fault", 0, fault_dbl)
        `CHK("reset event", 0, ecc_evt)
        sys_rst = 0;
        @(posedge clk);
        #1;
        ahb(0, SIZE_DWORD, 32'h0000_0300, 64'h0);
        `CHK("read after reset", 64'hA5A5_0F0F_1234_5678, rdat)
    endtask : t_reset

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // Whole run is near 90 cycles, so this only trips on a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        sys_rst = 1;
        hsel = 0;
        hwrite = 0;
        haddr = '0;
        htrans = 2'h0;
        hsize = SIZE_WORD;
        hwdata = '0;
        row_flip = 0;
        ecc_cfg = '0;
        ecc_cfg.check_en = 1;
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 0;
        @(posedge clk);
        #1;
        t_word();
        t_sub();
        t_dword();
        t_single();
        t_double();
        t_addr();
        t_reset();
        end_sim();
    end
endmodule : ecc_sram_array_controller_tb
